// ---- design/fpi_pkg.sv ----
// Constants and types shared by the fixed priority interrupt unit.
package fpi_pkg;

  // ==========================================================================
  // Register map (byte addresses, one word each)
  localparam logic [7:0] OFS_OPTION = 8'hc8;
  localparam logic [7:0] OFS_EVMASK = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;

  // ==========================================================================
  // Interrupt option fields and reset value
  localparam logic [7:0] OPTION_RESET = 8'h00;
  localparam logic [7:0] OPTION_USED = 8'h70;
  localparam int BIT_SRC1_LEVEL_SELECT = 6;
  localparam int BIT_SRC2_EDGE_POLARITY = 5;
  localparam int BIT_GLOBAL_IRQ_ENABLE = 4;

  // ==========================================================================
  // Event mask fields and reset value
  localparam logic [7:0] EVMASK_RESET = 8'h00;
  localparam logic [7:0] EVMASK_USED = 8'h1f;
  localparam int BIT_TIMER = 0;
  localparam int BIT_CONV = 1;
  localparam int BIT_SUPPLY = 2;
  localparam int BIT_OSC32 = 3;
  localparam int BIT_SPI = 4;

  // ==========================================================================
  // Vector addresses, stack and pin idle levels
  localparam logic [11:0] VEC_SRC0 = 12'hffc;
  localparam logic [11:0] VEC_SRC1 = 12'hff6;
  localparam logic [11:0] VEC_SRC2 = 12'hff4;
  localparam logic [11:0] VEC_SRC3 = 12'hff2;
  localparam logic [11:0] VEC_SRC4 = 12'hff0;
  localparam int STACK_DEPTH = 4;
  localparam logic [2:0] PIN_IDLE = 3'h3;

  // ==========================================================================
  // Types
  typedef enum logic [1:0] {
    MODE_NORMAL = 2'h0,
    MODE_IRQ = 2'h1,
    MODE_NMI = 2'h3
  } fpi_mode_t;

  typedef struct packed {
    fpi_mode_t mode;
    logic [11:0] pc;
  } fpi_frame_t;

  typedef struct packed {
    logic [7:0] option;
    logic [7:0] evmask;
    fpi_mode_t mode;
    logic nmi_lat;
    logic lat1;
    logic lat2;
    logic [2:0] pin_s1;
    logic [2:0] pin_s2;
    logic nmi_prev;
    logic sup_prev;
    logic line1_prev;
    logic src2_prev;
    logic [2:0] sp;
    fpi_frame_t [STACK_DEPTH-1:0] stack;
    logic [2:0][1:0] flag_sets;
    logic wb_ack;
    logic [31:0] wb_rdata;
    logic wake;
    logic sleep_block;
  } fpi_state_t;

  localparam fpi_state_t ST_RESET = '{
    option: OPTION_RESET,
    evmask: EVMASK_RESET,
    mode: MODE_NMI,
    pin_s1: PIN_IDLE,
    pin_s2: PIN_IDLE,
    default: '0
  };

endpackage

// ---- design/fpi_top.sv ----
// Fixed priority interrupt unit: request sensing, vectoring, flag sets, stack.
`timescale 1ns/1ns
// Summary of operation
// - NMI preempts all; maskable sources never nest.
// - Pending maskable sources served one through four.
// - Accepted source loads its own vector address.
// - Global enable masks maskables and gates wakeup.
// - NMI request latched, cleared when routine starts.
// - Source one level or falling edge selectable.
// - Source two edge only, polarity selectable.
// - Sources three and four always level sensitive.
// - Edge latch holds one request, cleared on entry.
// - Level requests unstored; requester holds its active level (pin low, event high).
// - Lines tested at instruction end; accept skips next.
// - Entry swaps flags, pushes PC, inhibits, loads vector.
// - Three flag sets switched automatically by mode.
// - Return restores previous flag set and PC.
// - Option register write-only, resets to zero.
// - Peripheral events ORed per source behind masks.
// - Conversion done requests source four when masked in.
// - Reset starts in NMI mode until first return.
// - Block sleep while enabled request pending.
module fpi_top
  import fpi_pkg::*;
(
  // Clock and reset.
  input wire logic MCLK_IN,
  input wire logic RESET_IN,
  // Wishbone slave.
  input wire logic WB_CYC_IN,
  input wire logic WB_STB_IN,
  input wire logic WB_WE_IN,
  input wire logic [7:0] WB_ADR_IN,
  input wire logic [3:0] WB_SEL_IN,
  input wire logic [31:0] WB_DAT_IN,
  output logic [31:0] WB_DAT_OUT,
  output logic WB_ACK_OUT,
  // External request pins.
  input wire logic NMI_N_IN,
  input wire logic SRC1_N_IN,
  input wire logic SRC2_IN,
  // Peripheral events.
  input wire logic TIMER_ZERO_FLAG_IN,
  input wire logic CONVERTER_DONE_IN,
  input wire logic SUPPLY_IRQ_FLAG_IN,
  input wire logic OSC32_DONE_FLAG_IN,
  input wire logic SPI_EOT_IN,
  // Core side.
  input wire logic INSTR_END_IN,
  input wire logic RETURN_FROM_IRQ_IN,
  input wire logic [11:0] PC_IN,
  input wire logic FLAG_WR_IN,
  input wire logic FLAG_C_IN,
  input wire logic FLAG_Z_IN,
  output logic ACCEPT_OUT,
  output logic [11:0] VECTOR_OUT,
  output logic RESTORE_OUT,
  output logic [11:0] RESTORE_PC_OUT,
  output logic FLAG_C_OUT,
  output logic FLAG_Z_OUT,
  output logic [1:0] MODE_OUT,
  output logic WAKE_OUT,
  output logic SLEEP_BLOCK_OUT
);

  // ==========================================================================
  // Helper functions

  // Maps a mode onto the index of its flag set.
  function automatic logic [1:0] mode_idx(input fpi_mode_t m);
    mode_idx = {m[1], m[0] & ~m[1]};
  endfunction

  // Lowest numbered pending maskable source wins; zero means none.
  function automatic logic [2:0] win_src(input logic [4:1] r);
    if (r[1])
      win_src = 3'h1;
    else if (r[2])
      win_src = 3'h2;
    else if (r[3])
      win_src = 3'h3;
    else if (r[4])
      win_src = 3'h4;
    else
      win_src = 3'h0;
  endfunction

  // Vector address of a source.
  function automatic logic [11:0] vec_of(input logic [2:0] s);
    case (s)
      3'h1: vec_of = VEC_SRC1;
      3'h2: vec_of = VEC_SRC2;
      3'h3: vec_of = VEC_SRC3;
      3'h4: vec_of = VEC_SRC4;
      default: vec_of = VEC_SRC0;
    endcase
  endfunction

  // ==========================================================================
  // State and combinational terms

  fpi_state_t st_r;
  fpi_state_t st_nxt;
  logic global_irq_enable;
  logic src1_level_select;
  logic src2_edge_polarity;
  logic nmi_line;
  logic sup_line;
  logic line1;
  logic edge1;
  logic edge2;
  logic nmi_edge;
  logic [4:1] req;
  logic [2:0] winner;
  logic take_nmi;
  logic take_irq;
  logic do_restore;
  logic wb_hit;
  logic [1:0] fidx;
  fpi_frame_t top_frame;
  logic [2:0] sp_dec;

  // Option bits that steer sensing and masking.
  assign global_irq_enable = st_r.option[BIT_GLOBAL_IRQ_ENABLE];
  assign src1_level_select = st_r.option[BIT_SRC1_LEVEL_SELECT];
  assign src2_edge_polarity = st_r.option[BIT_SRC2_EDGE_POLARITY];

  // Source lines, after synchronisers for the pins; events share one clock.
  assign nmi_line = ~st_r.pin_s2[0];
  assign sup_line = SUPPLY_IRQ_FLAG_IN & st_r.evmask[BIT_SUPPLY];
  assign nmi_edge = (nmi_line & ~st_r.nmi_prev) | (sup_line & ~st_r.sup_prev);
  assign line1 = ~st_r.pin_s2[1] | (SPI_EOT_IN & st_r.evmask[BIT_SPI]);
  assign edge1 = line1 & ~st_r.line1_prev;
  assign edge2 = src2_edge_polarity
               ? (st_r.pin_s2[2] & ~st_r.src2_prev)
               : (~st_r.pin_s2[2] & st_r.src2_prev);

  // Maskable requests: level sources are read live and never stored.
  assign req[1] = src1_level_select ? line1 : st_r.lat1;
  assign req[2] = st_r.lat2;
  assign req[3] = (TIMER_ZERO_FLAG_IN & st_r.evmask[BIT_TIMER])
                | (OSC32_DONE_FLAG_IN & st_r.evmask[BIT_OSC32]);
  assign req[4] = CONVERTER_DONE_IN & st_r.evmask[BIT_CONV];
  assign winner = win_src(req);

  // A return is handled alone; any request left pending is taken at the
  // next instruction end, so the return never races the entry.
  assign take_nmi = INSTR_END_IN & ~RETURN_FROM_IRQ_IN
                  & st_r.nmi_lat & (st_r.mode != MODE_NMI);
  assign take_irq = INSTR_END_IN & ~RETURN_FROM_IRQ_IN & ~take_nmi
                  & global_irq_enable
                  & (st_r.mode == MODE_NORMAL) & (winner != 3'h0);
  assign sp_dec = st_r.sp - 3'h1;
  assign top_frame = st_r.stack[sp_dec[1:0]];
  assign do_restore = RETURN_FROM_IRQ_IN & (st_r.sp != 3'h0);
  assign fidx = mode_idx(st_r.mode);
  assign wb_hit = WB_CYC_IN & WB_STB_IN;

  // The accept, vector and restore answer within the strobe's own cycle; these,
  // the restore PC and the flags are the outputs not taken straight from a flip-flop.
  assign ACCEPT_OUT = take_nmi | take_irq;
  assign VECTOR_OUT = take_nmi ? VEC_SRC0 : vec_of(winner);
  assign RESTORE_OUT = do_restore;
  assign RESTORE_PC_OUT = top_frame.pc;
  assign FLAG_C_OUT = st_r.flag_sets[fidx][1];
  assign FLAG_Z_OUT = st_r.flag_sets[fidx][0];

  // Registered outputs.
  assign MODE_OUT = st_r.mode;
  assign WAKE_OUT = st_r.wake;
  assign SLEEP_BLOCK_OUT = st_r.sleep_block;
  assign WB_ACK_OUT = st_r.wb_ack;
  assign WB_DAT_OUT = st_r.wb_rdata;

  // ==========================================================================
  // Next state

  // All state moves together; the entry steps land on one edge.
  always_comb
  begin
    st_nxt = st_r;

    // Two-stage synchronisers; stage one feeds stage two only.
    st_nxt.pin_s1 = {SRC2_IN, SRC1_N_IN, NMI_N_IN};
    st_nxt.pin_s2 = st_r.pin_s1;
    st_nxt.nmi_prev = nmi_line;
    st_nxt.sup_prev = sup_line;
    st_nxt.line1_prev = line1;
    st_nxt.src2_prev = st_r.pin_s2[2];

    // Latches: a new edge in the clearing cycle survives the clear.
    st_nxt.nmi_lat = (st_r.nmi_lat & ~take_nmi) | nmi_edge;
    st_nxt.lat1 = ~src1_level_select
                & ((st_r.lat1 & ~(take_irq & (winner == 3'h1))) | edge1);
    st_nxt.lat2 = (st_r.lat2 & ~(take_irq & (winner == 3'h2))) | edge2;

    // Core writes land in the flag set of the mode in force.
    if (FLAG_WR_IN)
    begin
      st_nxt.flag_sets[fidx] = {FLAG_C_IN, FLAG_Z_IN};
    end

    // Entry: new mode selects the new flag set, PC goes on the stack.
    if (take_nmi | take_irq)
    begin
      st_nxt.mode = take_nmi ? MODE_NMI : MODE_IRQ;
      if (st_r.sp < 3'(STACK_DEPTH))
      begin
        st_nxt.stack[st_r.sp[1:0]] = '{mode: st_r.mode, pc: PC_IN};
        st_nxt.sp = st_r.sp + 3'h1;
      end
      else
      begin
        // A full stack keeps its depth; the newest frame replaces the top.
        st_nxt.stack[sp_dec[1:0]] = '{mode: st_r.mode, pc: PC_IN};
      end
    end
    else if (RETURN_FROM_IRQ_IN)
    begin
      // An empty stack is the post-reset case: fall back to normal mode.
      if (do_restore)
      begin
        st_nxt.mode = top_frame.mode;
        st_nxt.sp = sp_dec;
      end
      else
      begin
        st_nxt.mode = MODE_NORMAL;
      end
    end

    // Wake and sleep guard; wake is wholly behind the global enable, the guard for maskables only.
    st_nxt.wake = global_irq_enable & (st_r.nmi_lat | (|req));
    st_nxt.sleep_block = st_r.nmi_lat | (global_irq_enable & (|req));

    // Classic Wishbone: ack one cycle after the strobe, then drop.
    st_nxt.wb_ack = wb_hit & ~st_r.wb_ack;
    if (wb_hit & ~st_r.wb_ack)
    begin
      case (WB_ADR_IN[7:2])
        OFS_EVMASK[7:2]: st_nxt.wb_rdata = {24'h00_0000, st_r.evmask};
        OFS_STATUS[7:2]: st_nxt.wb_rdata = {24'h00_0000, st_r.sp,
                                            st_r.lat2, st_r.lat1,
                                            st_r.nmi_lat, st_r.mode};
        default: st_nxt.wb_rdata = 32'h0000_0000;
      endcase
    end
    else
    begin
      st_nxt.wb_rdata = 32'h0000_0000;
    end

    // Writes commit at the edge where the master sees ack; byte lane 0
    // must be selected, since a narrower update is not a whole-byte write.
    if (wb_hit & WB_WE_IN & st_r.wb_ack & WB_SEL_IN[0])
    begin
      if (WB_ADR_IN[7:2] == OFS_OPTION[7:2])
      begin
        st_nxt.option = WB_DAT_IN[7:0] & OPTION_USED;
      end
      else if (WB_ADR_IN[7:2] == OFS_EVMASK[7:2])
      begin
        st_nxt.evmask = WB_DAT_IN[7:0] & EVMASK_USED;
      end
    end
  end

  // Synchronous reset loads the documented start state in NMI mode.
  always_ff @(posedge MCLK_IN)
  begin
    if (RESET_IN)
      st_r <= ST_RESET;
    else
      st_r <= st_nxt;
  end

  // ==========================================================================
  // Assertions

  default clocking cb @(posedge MCLK_IN);
  endclocking
  default disable iff (RESET_IN);

  sequence s_accept;
    ACCEPT_OUT && (st_r.sp < 3'(STACK_DEPTH));
  endsequence

  sequence s_restore;
    RESTORE_OUT && !ACCEPT_OUT;
  endsequence

  property p_push;
    s_accept |=> (st_r.sp == $past(st_r.sp) + 3'h1)
                 && (st_r.mode != MODE_NORMAL)
                 && (st_r.stack[sp_dec[1:0]].pc == $past(PC_IN));
  endproperty

  property p_pop;
    s_restore |=> (st_r.mode == $past(top_frame.mode))
                  && (st_r.sp == $past(sp_dec));
  endproperty

  a_entry_push: assert property (p_push)
    else $error("entry did not push PC and change mode");

  a_return_pop: assert property (p_pop)
    else $error("return did not restore mode and stack");

  a_no_nesting: assert property (
    (st_r.mode != MODE_NORMAL) && ACCEPT_OUT |-> VECTOR_OUT == VEC_SRC0)
    else $error("maskable source nested into a routine");

  a_global_mask: assert property (
    !global_irq_enable && ACCEPT_OUT
    |-> VECTOR_OUT == VEC_SRC0 && st_r.nmi_lat)
    else $error("maskable accept with global enable low");

  a_src1_first: assert property (
    take_irq && req[1] |-> VECTOR_OUT == VEC_SRC1)
    else $error("source one not served first");

  a_nmi_clear: assert property (
    take_nmi && !nmi_edge |=> !st_r.nmi_lat && st_r.mode == MODE_NMI)
    else $error("NMI latch not cleared on entry");

  a_reset_nmi: assert property (
    $past(RESET_IN) |-> st_r.mode == MODE_NMI && st_r.option == OPTION_RESET)
    else $error("not in NMI mode after reset");

  a_option_wo: assert property (
    wb_hit && !st_r.wb_ack && (WB_ADR_IN[7:2] == OFS_OPTION[7:2])
    |=> WB_ACK_OUT && WB_DAT_OUT == 32'h0000_0000)
    else $error("option register read back");

  a_wb_ack_once: assert property (
    WB_ACK_OUT |=> !WB_ACK_OUT)
    else $error("ack held longer than one cycle");

  a_src2_edge: assert property (
    edge2 |=> st_r.lat2)
    else $error("source two edge not latched");

  a_level_live: assert property (
    take_irq && (winner == 3'h4) |-> CONVERTER_DONE_IN
                                     && st_r.evmask[BIT_CONV])
    else $error("source four accepted without live masked request");

endmodule

// ---- verification/fpi_core_model.sv ----
// Partner model of the processor core: instruction ends, returns, flags.
`timescale 1ns/1ns
module fpi_core_model
  import fpi_pkg::*;
(
  // Clock and answers from the unit.
  input wire logic clk_in,
  input wire logic accept_in,
  input wire logic restore_in,
  input wire logic [11:0] vector_in,
  input wire logic [11:0] restore_pc_in,
  // Strobes and data towards the unit.
  output logic instr_end_out = 1'b0,
  output logic return_from_irq_instr_out = 1'b0,
  output logic [11:0] pc_out = 12'h000,
  output logic flag_wr_out = 1'b0,
  output logic flag_c_out = 1'b0,
  output logic flag_z_out = 1'b0
);
  // ==========================================================================
  // Transactions
  // One instruction end. The answer is combinational, so it is taken at
  // the edge that ends the strobe; one more edge lets the registers land.
  task automatic step(input logic [11:0] pc, input logic ret,
    output logic acc, output logic rs, output logic [11:0] vec,
    output logic [11:0] rpc);
    @(posedge clk_in);
    instr_end_out <= 1'b1;
    return_from_irq_instr_out <= ret;
    pc_out <= pc;
    @(posedge clk_in);
    acc = accept_in;
    rs = restore_in;
    vec = vector_in;
    rpc = restore_pc_in;
    instr_end_out <= 1'b0;
    return_from_irq_instr_out <= 1'b0;
    pc_out <= ~pc; // A stale PC must never look valid.
    @(posedge clk_in);
  endtask

  // Writes carry and zero into whichever flag set is active.
  task automatic set_flags(input logic c, input logic z);
    @(posedge clk_in);
    flag_wr_out <= 1'b1;
    flag_c_out <= c;
    flag_z_out <= z;
    @(posedge clk_in);
    flag_wr_out <= 1'b0;
  endtask
endmodule

// ---- verification/tb_fixed_priority_irq_unit.sv ----
// Self-checking bench for the fixed priority interrupt unit.
`timescale 1ns/1ns
module tb_fixed_priority_irq_unit
  import fpi_pkg::*;
;
  // ==========================================================================
  // Signals
  logic clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [3:0] sel = 4'h0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wd = 32'h0000_0000, rd, q;
  logic ack, acc, rs, fco, fzo, wake, blk, ie, rt, fw, fc, fz;
  logic nmi = 1'b1, s1 = 1'b1, s2 = 1'b1;
  logic tzf = 1'b0, cnv = 1'b0, sup = 1'b0, osc = 1'b0, eot = 1'b0;
  logic [11:0] pc, vec, rpc, a_vec, a_rpc, p;
  logic [1:0] mode;
  logic a_acc, a_rs;
  int seed = 14, bad_count = 0, n_checks = 0, ticks = 0;

  // Clock generator.
  always #5 clk = ~clk;

  fpi_top dut (.MCLK_IN(clk), .RESET_IN(rst), .WB_CYC_IN(cyc),
    .WB_STB_IN(stb), .WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(sel),
    .WB_DAT_IN(wd), .WB_DAT_OUT(rd), .WB_ACK_OUT(ack), .NMI_N_IN(nmi),
    .SRC1_N_IN(s1), .SRC2_IN(s2), .TIMER_ZERO_FLAG_IN(tzf),
    .CONVERTER_DONE_IN(cnv), .SUPPLY_IRQ_FLAG_IN(sup),
    .OSC32_DONE_FLAG_IN(osc), .SPI_EOT_IN(eot), .INSTR_END_IN(ie),
    .RETURN_FROM_IRQ_IN(rt), .PC_IN(pc), .FLAG_WR_IN(fw), .FLAG_C_IN(fc),
    .FLAG_Z_IN(fz), .ACCEPT_OUT(acc), .VECTOR_OUT(vec),
    .RESTORE_OUT(rs), .RESTORE_PC_OUT(rpc), .FLAG_C_OUT(fco),
    .FLAG_Z_OUT(fzo), .MODE_OUT(mode), .WAKE_OUT(wake),
    .SLEEP_BLOCK_OUT(blk));

  fpi_core_model core (.clk_in(clk), .accept_in(acc), .restore_in(rs),
    .vector_in(vec), .restore_pc_in(rpc), .instr_end_out(ie),
    .return_from_irq_instr_out(rt), .pc_out(pc), .flag_wr_out(fw), .flag_c_out(fc),
    .flag_z_out(fz));

  // ==========================================================================
  // Tasks
  task automatic chk(input string nm, input logic [31:0] e,
    input logic [31:0] g);
    n_checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Classic single cycle; the request is held until ack is sampled.
  task automatic wb(input logic w, input logic [7:0] a,
    input logic [31:0] d, input logic [3:0] s, output logic [31:0] r);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wd <= d;
    sel <= s;
    @(posedge clk);
    while (ack !== 1'b1)
      @(posedge clk);
    r = rd;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  // Source vector that each peripheral event is routed to.
  function automatic logic [11:0] ev_vec(input int i);
    case (i)
      0: ev_vec = VEC_SRC3;
      1: ev_vec = VEC_SRC4;
      2: ev_vec = VEC_SRC0;
      3: ev_vec = VEC_SRC3;
      default: ev_vec = VEC_SRC1;
    endcase
  endfunction

  // Pins pass a two-stage synchroniser, so give them time to land.
  task automatic w6;
    repeat (6) @(posedge clk);
  endtask

  // One strobe with a random PC; a taken request is returned from at once.
  // The PC is local, so an outer routine's saved PC is not overwritten.
  task automatic hit(input logic e, input logic [11:0] v);
    logic [11:0] hp;
    hp = 12'($random(seed));
    core.step(hp, 1'b0, a_acc, a_rs, a_vec, a_rpc);
    chk("accept", 32'(e), 32'(a_acc));
    if (e)
    begin
      chk("vector", 32'(v), 32'(a_vec));
      core.step(12'h000, 1'b1, a_acc, a_rs, a_vec, a_rpc);
      chk("restore", 32'h0000_0001, 32'(a_rs));
      chk("return pc", 32'(hp), 32'(a_rpc));
    end
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // A hang counts as a mismatch; the whole run needs under 2000 cycles.
  always @(posedge clk)
  begin
    ticks <= ticks + 1;
    if (ticks == 5000)
    begin
      bad_count++;
      close_out;
    end
  end

  // ==========================================================================
  // Main sequence
  initial
  begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    wb(1'b0, OFS_OPTION, 32'h0000_0000, 4'h1, q);
    chk("option read", 32'h0000_0000, q);
    chk("reset mode", 32'(MODE_NMI), 32'(mode));
    wb(1'b0, OFS_STATUS, 32'h0000_0000, 4'h1, q);
    chk("status", 32'(MODE_NMI), q);
    wb(1'b1, OFS_EVMASK, 32'h0000_001f, 4'h1, q);
    wb(1'b0, OFS_EVMASK, 32'h0000_0000, 4'h1, q);
    chk("evmask", 32'h0000_001f, q);
    wb(1'b1, OFS_OPTION, 32'h0000_0010, 4'h1, q);
    wb(1'b0, OFS_OPTION, 32'h0000_0000, 4'h1, q);
    chk("option read", 32'h0000_0000, q);
    tzf <= 1'b1;
    core.set_flags(1'b1, 1'b1);
    hit(1'b0, VEC_SRC3);
    chk("nmi z flag", 32'h0000_0001, 32'(fzo));
    core.step(12'h000, 1'b1, a_acc, a_rs, a_vec, a_rpc);
    chk("empty restore", 32'h0000_0000, 32'(a_rs));
    chk("mode", 32'(MODE_NORMAL), 32'(mode));
    chk("normal flag", 32'h0000_0000, 32'(fco));
    core.set_flags(1'b1, 1'b0);
    p = 12'($random(seed));
    core.step(p, 1'b0, a_acc, a_rs, a_vec, a_rpc);
    chk("accept", 32'h0000_0001, 32'(a_acc));
    chk("vector", 32'(VEC_SRC3), 32'(a_vec));
    chk("mode", 32'(MODE_IRQ), 32'(mode));
    chk("irq flag", 32'h0000_0000, 32'(fco));
    chk("irq z flag", 32'h0000_0000, 32'(fzo));
    cnv <= 1'b1;
    hit(1'b0, VEC_SRC4);
    nmi <= 1'b0;
    w6;
    hit(1'b1, VEC_SRC0);
    nmi <= 1'b1;
    chk("mode", 32'(MODE_IRQ), 32'(mode));
    hit(1'b0, VEC_SRC0);
    core.step(12'h000, 1'b1, a_acc, a_rs, a_vec, a_rpc);
    chk("return pc", 32'(p), 32'(a_rpc));
    chk("normal flag", 32'h0000_0001, 32'(fco));
    chk("normal z flag", 32'h0000_0000, 32'(fzo));
    hit(1'b1, VEC_SRC3);
    tzf <= 1'b0;
    hit(1'b1, VEC_SRC4);
    cnv <= 1'b0;
    $display("test nesting done");
    // Global enable, refused partial write, wake and sleep blocking.
    tzf <= 1'b1;
    wb(1'b1, OFS_OPTION, 32'h0000_0000, 4'h1, q);
    hit(1'b0, VEC_SRC3);
    wb(1'b1, OFS_OPTION, 32'h0000_0010, 4'h2, q);
    hit(1'b0, VEC_SRC3);
    chk("wake", 32'h0000_0000, 32'(wake));
    chk("block", 32'h0000_0000, 32'(blk));
    wb(1'b1, OFS_OPTION, 32'h0000_0010, 4'h1, q);
    w6;
    chk("wake", 32'h0000_0001, 32'(wake));
    chk("block", 32'h0000_0001, 32'(blk));
    tzf <= 1'b0;
    wb(1'b1, OFS_OPTION, 32'h0000_0000, 4'h1, q);
    nmi <= 1'b0;
    w6;
    chk("wake", 32'h0000_0000, 32'(wake));
    chk("block", 32'h0000_0001, 32'(blk));
    hit(1'b1, VEC_SRC0);
    nmi <= 1'b1;
    $display("test enable done");
    // Each event raises its source only behind its own mask bit.
    wb(1'b1, OFS_OPTION, 32'h0000_0050, 4'h1, q);
    for (int i = 0; i < 5; i++)
    begin
      for (int m = 0; m < 2; m++)
      begin
        wb(1'b1, OFS_EVMASK, 32'(m << i), 4'h1, q);
        {eot, osc, sup, cnv, tzf} <= 5'(1 << i);
        w6;
        hit(1'(m), ev_vec(i));
        {eot, osc, sup, cnv, tzf} <= 5'h00;
      end
    end
    $display("test events done");
    // Edge latches: falling edges, one stored request, polarity, level.
    wb(1'b1, OFS_OPTION, 32'h0000_0010, 4'h1, q);
    repeat (2)
    begin
      s2 <= 1'b0;
      w6;
      s2 <= 1'b1;
      w6;
    end
    s1 <= 1'b0;
    w6;
    s1 <= 1'b1;
    w6;
    hit(1'b1, VEC_SRC1);
    hit(1'b1, VEC_SRC2);
    hit(1'b0, VEC_SRC2);
    wb(1'b1, OFS_OPTION, 32'h0000_0030, 4'h1, q);
    s2 <= 1'b0;
    w6;
    hit(1'b0, VEC_SRC2);
    s2 <= 1'b1;
    w6;
    hit(1'b1, VEC_SRC2);
    wb(1'b1, OFS_OPTION, 32'h0000_0050, 4'h1, q);
    s1 <= 1'b0;
    w6;
    hit(1'b1, VEC_SRC1);
    s1 <= 1'b1;
    w6;
    hit(1'b0, VEC_SRC1);
    $display("test edges done");
    close_out;
  end
endmodule
